//--- olpc_arb_if.sv
// carrier between top and control/bulk ratio arbiter
`timescale 1ns/1ps
`default_nettype none
interface olpc_arb_if;
	logic [1:0] ratio;
	logic ctrl_ok;
	logic bulk_ok;
	logic ctrl_done;
	logic bulk_done;
	logic pick_ctrl;
	logic pick_bulk;
	modport top (output ratio, output ctrl_ok, output bulk_ok, output ctrl_done, output bulk_done,
		input pick_ctrl, input pick_bulk);
	modport arb (input ratio, input ctrl_ok, input bulk_ok, input ctrl_done, input bulk_done,
		output pick_ctrl, output pick_bulk);
endinterface
`default_nettype wire

//--- olpc_pkg.sv
// constants for the list-processing control register bank
package olpc_pkg;
	// ==========================
	// register map
	localparam logic [7:0] CTRL_OFFSET = 8'h04;
	localparam int DATA_W = 32;
	// ==========================
	// field positions
	localparam int BIT_RATIO_LO = 0;
	localparam int BIT_RATIO_HI = 1;
	localparam int BIT_PLE = 2;
	localparam int BIT_IE = 3;
	localparam int BIT_CLE = 4;
	localparam int BIT_BLE = 5;
	localparam int BIT_FS_LO = 6;
	localparam int BIT_FS_HI = 7;
	localparam int RATIO_W = 2;
	// ==========================
	// functional states
	typedef enum logic [1:0] {
		bus_reset_state = 2'b00,
		bus_resume_state = 2'b01,
		bus_running_state = 2'b10,
		bus_suspended_state = 2'b11
	} olpc_fs_t;
	// ==========================
	// reset values
	localparam logic [1:0] RATIO_RST = 2'h0;
	localparam logic [2:0] CNT_RST = 3'h0;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// ==========================
	// timing
	localparam int CLK_MHZ = 40;
	localparam int PORT_RESET_US = 10;
	localparam int PORT_RESET_CYC = PORT_RESET_US * CLK_MHZ;
endpackage

//--- olpc_ratio_arb.sv
// control-over-bulk service ratio counter and selector
`timescale 1ns/1ps
`default_nettype none
module olpc_ratio_arb (
	input wire logic clk,
	input wire logic rst_n,
	olpc_arb_if.arb a
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [2:0] limit;
	logic ratio_left;
	// ==========================
	// decision
	assign limit = {1'b0, a.ratio} + 3'h1;
	assign ratio_left = cnt_q < limit;
	assign a.pick_ctrl = a.ctrl_ok & (ratio_left | ~a.bulk_ok);
	assign a.pick_bulk = a.bulk_ok & ~a.pick_ctrl;
	assign cnt_d = a.bulk_done ? olpc_pkg::CNT_RST :
		(a.ctrl_done & ratio_left) ? cnt_q + 3'h1 : cnt_q;
	// ==========================
	// count register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= olpc_pkg::CNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // olpc_ratio_arb
`default_nettype wire

//--- olpc_top.sv
// list-processing control register and schedule gating
`timescale 1ns/1ps
`default_nettype none
module olpc_top #(
	parameter int PORT_RESET_CYC = olpc_pkg::PORT_RESET_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	input wire logic sof_pulse,
	input wire logic resume_pin,
	input wire logic periodic_query,
	input wire logic iso_query,
	input wire logic nonper_query,
	input wire logic ctrl_avail,
	input wire logic bulk_avail,
	input wire logic ctrl_done,
	input wire logic bulk_done,
	output logic periodic_go,
	output logic iso_continue,
	output logic iso_halt,
	output logic serve_ctrl,
	output logic serve_bulk,
	output logic root_hub_reset,
	output logic port_reset
);
	olpc_arb_if arb_bus ();
	logic [1:0] fs_q;
	logic [1:0] fs_d;
	logic ble_q, cle_q, ie_q, ple_q;
	logic ble_f_q, cle_f_q, ie_f_q, ple_f_q;
	logic [1:0] ratio_q;
	logic res_s1_q, res_s2_q;
	logic hit_wr, hit_rd;
	logic bulk_ok, ctrl_ok, per_ok, iso_ok;
	logic [31:0] rd_word;
	logic [15:0] rst_cnt_q;
	logic rh_q, pr_q;
	// ==========================
	// decode
	assign hit_wr = reg_wr & (reg_addr == olpc_pkg::CTRL_OFFSET);
	assign hit_rd = reg_rd & (reg_addr == olpc_pkg::CTRL_OFFSET);
	assign rd_word = {24'h00_0000, fs_q, ble_q, cle_q, ie_q, ple_q, ratio_q};
	// ==========================
	// functional state
	always_comb begin
		fs_d = fs_q;
		if (hit_wr) begin
			fs_d = reg_wdata[olpc_pkg::BIT_FS_HI:olpc_pkg::BIT_FS_LO];
		end else if (res_s2_q && fs_q == olpc_pkg::bus_suspended_state) begin
			fs_d = olpc_pkg::bus_resume_state;
		end
		if (soft_reset) begin
			fs_d = olpc_pkg::bus_suspended_state;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_q <= olpc_pkg::bus_reset_state;
			res_s1_q <= 1'b0;
			res_s2_q <= 1'b0;
		end else begin
			fs_q <= fs_d;
			res_s1_q <= resume_pin;
			res_s2_q <= res_s1_q;
		end
	end
	// ==========================
	// control bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ble_q, cle_q, ie_q, ple_q} <= 4'h0;
			ratio_q <= olpc_pkg::RATIO_RST;
		end else if (soft_reset) begin
			{ble_q, cle_q, ie_q, ple_q} <= 4'h0;
			ratio_q <= olpc_pkg::RATIO_RST;
		end else if (hit_wr) begin
			ble_q <= reg_wdata[olpc_pkg::BIT_BLE];
			cle_q <= reg_wdata[olpc_pkg::BIT_CLE];
			ie_q <= reg_wdata[olpc_pkg::BIT_IE];
			ple_q <= reg_wdata[olpc_pkg::BIT_PLE];
			ratio_q <= reg_wdata[olpc_pkg::BIT_RATIO_HI:olpc_pkg::BIT_RATIO_LO];
		end
	end
	// ==========================
	// per-frame copies taken at frame start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ble_f_q, cle_f_q, ie_f_q, ple_f_q} <= 4'h0;
		end else if (sof_pulse) begin
			ble_f_q <= ble_q;
			cle_f_q <= cle_q;
			ie_f_q <= ie_q;
			ple_f_q <= ple_q;
		end
	end
	assign bulk_ok = bulk_avail & ble_q & ble_f_q;
	assign ctrl_ok = ctrl_avail & cle_q & cle_f_q;
	assign per_ok = ple_q & ple_f_q;
	assign iso_ok = ie_q & ie_f_q;
	// ==========================
	// ratio arbiter
	assign arb_bus.ratio = ratio_q;
	assign arb_bus.ctrl_ok = ctrl_ok;
	assign arb_bus.bulk_ok = bulk_ok;
	assign arb_bus.ctrl_done = ctrl_done;
	assign arb_bus.bulk_done = bulk_done;
	olpc_ratio_arb u_arb (
		.clk(clk),
		.rst_n(rst_n),
		.a(arb_bus.arb)
	);
	// ==========================
	// answers to the list engine and bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= olpc_pkg::ZERO_WORD;
			reg_ack <= 1'b0;
			periodic_go <= 1'b0;
			iso_continue <= 1'b0;
			iso_halt <= 1'b0;
			serve_ctrl <= 1'b0;
			serve_bulk <= 1'b0;
		end else begin
			reg_rdata <= hit_rd ? rd_word : olpc_pkg::ZERO_WORD;
			reg_ack <= reg_wr | reg_rd;
			periodic_go <= periodic_query & per_ok;
			iso_continue <= iso_query & iso_ok;
			iso_halt <= iso_query & ~iso_ok;
			serve_ctrl <= nonper_query & arb_bus.pick_ctrl;
			serve_bulk <= nonper_query & arb_bus.pick_bulk;
		end
	end
	// ==========================
	// root hub then port reset after hard reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rh_q <= 1'b1;
			pr_q <= 1'b0;
			rst_cnt_q <= 16'h0000;
		end else if (rh_q) begin
			rh_q <= 1'b0;
			pr_q <= 1'b1;
			rst_cnt_q <= 16'h0000;
		end else if (pr_q) begin
			rst_cnt_q <= rst_cnt_q + 16'h0001;
			if (rst_cnt_q == 16'(PORT_RESET_CYC - 1)) begin
				pr_q <= 1'b0;
			end
		end
	end
	assign root_hub_reset = rh_q;
	assign port_reset = pr_q;
endmodule // olpc_top
`default_nettype wire

//--- olpc_top_assertions.sv
// concurrent checks on the list-processing control ports
`timescale 1ns/1ps
`default_nettype none
module olpc_checker #(
	parameter int PORT_RESET_CYC = olpc_pkg::PORT_RESET_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic periodic_query,
	input wire logic iso_query,
	input wire logic nonper_query,
	input wire logic ctrl_avail,
	input wire logic bulk_avail,
	input wire logic periodic_go,
	input wire logic iso_continue,
	input wire logic iso_halt,
	input wire logic serve_ctrl,
	input wire logic serve_bulk,
	input wire logic root_hub_reset,
	input wire logic port_reset
);
	logic [15:0] pr_cnt_q;
	// ==========================
	// port reset length counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pr_cnt_q <= 16'h0000;
		end else if (port_reset) begin
			pr_cnt_q <= pr_cnt_q + 16'h0001;
		end else begin
			pr_cnt_q <= 16'h0000;
		end
	end
	// ==========================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_port;
		!root_hub_reset && port_reset && pr_cnt_q == 16'h0000;
	endsequence
	a_hub_then_port: assert property (root_hub_reset |=> s_port) else $error("port reset start");
	a_port_hold: assert property (port_reset && pr_cnt_q < 16'(PORT_RESET_CYC - 1) |=> port_reset)
		else $error("port reset short");
	a_port_end: assert property (port_reset && pr_cnt_q == 16'(PORT_RESET_CYC - 1) |=> !port_reset)
		else $error("port reset long");
	a_soft_susp: assert property (soft_reset ##1 (reg_rd && reg_addr == 8'h04) |=> reg_rdata[7:0] == 8'hc0)
		else $error("soft state");
	a_ctrl_gate: assert property (nonper_query && !ctrl_avail |=> !serve_ctrl) else $error("ctrl");
	a_bulk_gate: assert property (nonper_query && !bulk_avail |=> !serve_bulk) else $error("bulk");
	a_one_list: assert property (!(serve_ctrl && serve_bulk)) else $error("two lists");
	a_per_cause: assert property (periodic_go |-> $past(periodic_query)) else $error("periodic");
	a_iso_pair: assert property (iso_query |=> iso_continue ^ iso_halt) else $error("iso answer");
	a_iso_cause: assert property (iso_continue || iso_halt |-> $past(iso_query)) else $error("iso");
endmodule // olpc_checker
bind olpc_top olpc_checker #(.PORT_RESET_CYC(PORT_RESET_CYC)) u_chk (.clk, .rst_n, .soft_reset, .reg_rd,
	.reg_addr, .reg_rdata, .periodic_query, .iso_query, .nonper_query, .ctrl_avail, .bulk_avail, .periodic_go,
	.iso_continue, .iso_halt, .serve_ctrl, .serve_bulk, .root_hub_reset, .port_reset);
`default_nettype wire

//--- olpc_top_tb.sv
// self-checking bench for the list-processing control bank
`timescale 1ns/1ps
`default_nettype none
module olpc_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic resume_pin = 1'b0;
	logic soft_reset, reg_wr, reg_rd, sof_pulse, periodic_query, iso_query, nonper_query;
	logic ctrl_avail, bulk_avail, ctrl_done, bulk_done;
	logic reg_ack, periodic_go, iso_continue, iso_halt, serve_ctrl, serve_bulk, root_hub_reset, port_reset;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, r;
	logic [36:0] q[$];
	logic [36:0] e, g;
	localparam int PR_CYC = 4;
	logic [11:0] c;
	logic [1:0] rs = 2'b00;
	int pr_n = 0;
	logic [7:0] rv = 8'h00;
	logic [3:0] lat = 4'h0;
	logic [2:0] cnt = 3'h0;
	int fails = 0;
	int n_checks = 0;
	olpc_top #(.PORT_RESET_CYC(PR_CYC)) dut (.clk, .rst_n, .soft_reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_ack, .sof_pulse, .resume_pin, .periodic_query, .iso_query, .nonper_query, .ctrl_avail,
		.bulk_avail, .ctrl_done, .bulk_done, .periodic_go, .iso_continue, .iso_halt, .serve_ctrl, .serve_bulk,
		.root_hub_reset, .port_reset);
	initial forever #12.5 clk = ~clk;
	// ==========================
	// drivers and model
	task drv(input logic [11:0] k, input logic [7:0] a, input logic [31:0] d);
		{resume_pin, soft_reset, bulk_done, ctrl_done, bulk_avail, ctrl_avail, nonper_query, iso_query, periodic_query,
			sof_pulse, reg_rd, reg_wr} = k;
		reg_addr = a;
		reg_wdata = d;
	endtask
	task automatic op(input logic [11:0] k, input logic [7:0] a, input logic [31:0] d);
		logic hit, ce, be, pc;
		hit = a == 8'h04;
		ce = rv[4] & lat[2];
		be = rv[5] & lat[3] & k[7];
		pc = k[5] & k[6] & ce & ({1'b0, rv[1:0]} >= cnt | !be);
		@(posedge clk);
		#2 drv(k, a, d);
		q.push_back({k[3] & rv[2] & lat[0], k[4] & rv[3] & lat[1], k[4] & !(rv[3] & lat[1]), pc, k[5] & be & !pc,
			k[1] & hit ? {24'h00_0000, rv} : 32'h0000_0000});
		if (k[8] && cnt <= {1'b0, rv[1:0]}) cnt++;
		if (k[9]) cnt = 3'h0;
		if (k[2]) lat = rv[5:2];
		if (k[0] && hit) rv = d[7:0];
		else if (rs[1] && rv[7:6] == 2'b11) rv[7:6] = 2'b01;
		if (k[10]) rv = 8'hc0;
		rs = {rs[0], k[11]};
	endtask
	task final_report;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ==========================
	// monitor
	always @(negedge clk) begin
		if (port_reset === 1'b1) pr_n++;
		if (reg_ack === 1'b1) begin
			e = q.pop_front();
			g = {periodic_go, iso_continue, iso_halt, serve_ctrl, serve_bulk, reg_rdata};
			n_checks++;
			if (g !== e) begin
				fails++;
				$display("BAD t=%0t exp=%h got=%h", $time, e, g);
			end
		end
	end
	initial begin
		#(25 * 10000);
		fails++;
		final_report;
	end
	// ==========================
	// tests
	initial begin
		drv(12'h000, 8'h00, 32'h0000_0000);
		r = $urandom(32'h0000_dddc);
		repeat (5) @(posedge clk);
		#2 rst_n = 1'b1;
		n_checks++;
		if (root_hub_reset !== 1'b1) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, 1'b1, root_hub_reset);
		end
		op(12'h002, 8'h04, 32'h0000_0000);
		op(12'h002, 8'h08, 32'h0000_0000);
		$display("test reset done");
		op(12'h401, 8'h04, 32'hffff_ffff);
		op(12'h002, 8'h04, 32'h0000_0000);
		$display("test soft done");
		repeat (3) op(12'h802, 8'h08, 32'h0000_0000);
		op(12'h002, 8'h04, 32'h0000_0000);
		$display("test resume done");
		op(12'h001, 8'h04, 32'h0000_0083);
		op(12'h0e2, 8'h08, 32'h0000_0000);
		op(12'h001, 8'h04, 32'h0000_00b3);
		op(12'h006, 8'h08, 32'h0000_0000);
		op(12'h0e2, 8'h04, 32'h0000_0000);
		$display("test edit done");
		for (int i = 0; i < 3000; i++) begin
			r = $urandom;
			c = r[11:0];
			c[0] = r[0] & r[1];
			c[1] = !c[0];
			c[2] = r[2] & r[11] & r[12];
			c[8] = r[8] & r[13];
			c[9] = r[9] & r[14] & !c[8];
			c[10] = &r[20:15];
			c[11] = r[24] & r[25];
			op(c, (&r[23:21]) ? 8'h08 : 8'h04, $urandom);
		end
		$display("test random done");
		@(posedge clk);
		#2 drv(12'h000, 8'h00, 32'h0000_0000);
		repeat (3) @(posedge clk);
		n_checks++;
		if (pr_n != PR_CYC) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, PR_CYC, pr_n);
		end
		final_report;
	end
endmodule // olpc_top_tb
`default_nettype wire
